// [dcoat_pkg.sv]
// Purpose: Constants for the termination, calibration, timing, aging block
// Assumes: 64-bit registers at their printed byte offsets
// Notes:   Functional notes below
// Functional notes
// - Read to select 2, 1 or 0 drives termination from that select's map.
// - Read to select 3 drives termination from select 3's own map.
// - Hold 5-bit pull-up calibration; send it in init driver commands.
// - Hold 5-bit pull-down calibration; send it in init driver commands.
// - After precharge, wait programmed cycles before bank takes commands.
// - Write with auto-precharge blocks bank for combined recovery count.
// - Combined recovery count is ignored unless auto-precharge is enabled.
// - Record host-port command errors in a read-only 4-bit code.
// - Load each newly queued command's age from the initial age value.
// - A second 6-bit age value paces the aging algorithm.
package dcoat_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 64;
  localparam int NUM_CS = 4;
  localparam int NUM_BANK = 8;
  localparam int NUM_SLOT = 4;

  // Register byte offsets
  localparam logic [11:0] OFF_TERM_MAP = 12'h080;
  localparam logic [11:0] OFF_OCD_PRE = 12'h090;
  localparam logic [11:0] OFF_AGING = 12'h0a0;
  localparam logic [11:0] OFF_CTRL = 12'h1f0;
  localparam logic [11:0] OFF_STATUS = 12'h1f8;

  // Field positions
  localparam int TERM_MAP_LSB0 = 0;
  localparam int TERM_MAP_LSB1 = 8;
  localparam int TERM_MAP_LSB2 = 16;
  localparam int TERM_MAP_LSB3 = 24;
  localparam int PULLUP_LSB = 56;
  localparam int PULLDOWN_LSB = 48;
  localparam int PRE_WAIT_LSB = 40;
  localparam int AP_REC_LSB = 32;
  localparam int CMD_ERR_LSB = 16;
  localparam int AGE_INIT_LSB = 32;
  localparam int AGE_PARAM_LSB = 24;
  localparam int CTRL_AP_EN_BIT = 0;
  localparam int CTRL_AGING_EN_BIT = 1;
  localparam int CTRL_ERR_CLR_LSB = 4;
  localparam int STAT_OCD_DONE_BIT = 0;
  localparam int STAT_BANK_RDY_LSB = 8;
  localparam int STAT_EXPIRED_LSB = 16;

  // Reset values
  localparam logic [3:0] TERM_MAP_RST = 4'h0;
  localparam logic [4:0] CAL_RST = 5'h00;
  localparam logic [3:0] TIMING_RST = 4'h0;
  localparam logic [3:0] CMD_ERR_RST = 4'h0;
  localparam logic [5:0] AGE_RST = 6'h00;

  // Error code bits
  localparam int ERR_WIDTH_BIT = 0;
  localparam int ERR_CWF_ALIGN_BIT = 1;
  localparam int ERR_CWF_POW2_BIT = 2;
  localparam int ERR_NARROW_BIT = 3;

  typedef enum logic [2:0] {
    OCD_IDLE  = 3'b001,
    OCD_ISSUE = 3'b010,
    OCD_DONE  = 3'b100
  } dcoat_ocd_state_type;

endpackage

// [dcoat_aging.sv]
// Purpose: Age counters for queued commands, with starvation priority
// Assumes: One enqueue and one service event at most per cycle
// Notes:   Step counter paces the countdown by services, not cycles
`timescale 1ns/10ps
module dcoat_aging
  import dcoat_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                enable,
  input  wire logic [5:0]          age_initial,
  input  wire logic [5:0]          age_param,
  input  wire logic                enq_valid,
  input  wire logic [1:0]          enq_slot,
  input  wire logic                svc_valid,
  input  wire logic [1:0]          svc_slot,
  output logic      [NUM_SLOT-1:0] slot_busy,
  output logic      [NUM_SLOT-1:0] expired,
  output logic                     prio_valid,
  output logic      [1:0]          prio_slot
);

  logic [5:0] step_reg;
  logic [5:0] step_next;
  logic       step_hit;
  logic [5:0] age_reg [NUM_SLOT];
  logic [NUM_SLOT-1:0] busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Step pacing
  assign step_hit  = enable && svc_valid && (step_reg >= age_param);
  assign step_next = step_hit ? 6'h00
                   : (svc_valid ? step_reg + 6'h01 : step_reg);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      step_reg <= 6'h00;
    else if (ce && enable)
      step_reg <= step_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot ages
  genvar s;
  generate
    for (s = 0; s < NUM_SLOT; s++)
    begin : g_slot
      wire logic load = enq_valid && (enq_slot == 2'(s));
      wire logic done = svc_valid && (svc_slot == 2'(s));
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          age_reg[s]  <= AGE_RST;
          busy_reg[s] <= 1'b0;
        end
        else if (ce)
        begin
          if (load)
          begin
            age_reg[s]  <= age_initial;
            busy_reg[s] <= 1'b1;
          end
          else if (done)
            busy_reg[s] <= 1'b0;
          else if (step_hit && busy_reg[s] && age_reg[s] != 6'h00)
            age_reg[s] <= age_reg[s] - 6'h01;
        end
      end
      assign expired[s] = enable && busy_reg[s] && age_reg[s] == 6'h00;
    end
  endgenerate

  assign slot_busy = busy_reg;

  // Lowest expired slot wins; starvation beats reordering
  assign prio_valid = |expired;
  assign prio_slot  = expired[0] ? 2'h0 : expired[1] ? 2'h1
                    : expired[2] ? 2'h2 : 2'h3;

endmodule // dcoat_aging

// [dcoat_ctrl.sv]
// Purpose: Read termination, driver calibration, bank timing, error code
// Assumes: Command inputs synchronous to clock, one-cycle strobes
// Notes:   Registers reached over a plain strobe port, read data next cycle
`timescale 1ns/10ps
module dcoat_ctrl
  import dcoat_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire logic                rd_cmd_valid,
  input  wire logic [1:0]          rd_cmd_sel,
  output logic      [NUM_CS-1:0]   term_enable,
  input  wire logic                ocd_init_start,
  input  wire logic                ocd_cmd_ack,
  output logic                     ocd_cmd_valid,
  output logic      [4:0]          ocd_pullup,
  output logic      [4:0]          ocd_pulldown,
  input  wire logic                precharge_issue,
  input  wire logic [2:0]          precharge_bank,
  input  wire logic                write_ap_issue,
  input  wire logic [2:0]          write_ap_bank,
  output logic      [NUM_BANK-1:0] bank_ready,
  input  wire logic                host_err_valid,
  input  wire logic [3:0]          host_err_code,
  input  wire logic                enq_valid,
  input  wire logic [1:0]          enq_slot,
  input  wire logic                svc_valid,
  input  wire logic [1:0]          svc_slot,
  output logic      [NUM_SLOT-1:0] slot_busy,
  output logic                     prio_valid,
  output logic      [1:0]          prio_slot
);

  ////////////////////////////////////////////////////////////////////////////
  // Register fields
  logic [3:0] read_term_map_sel0_reg;
  logic [3:0] read_term_map_sel1_reg;
  logic [3:0] read_term_map_sel2_reg;
  logic [3:0] read_term_map_sel3_reg;
  logic [4:0] driver_pullup_cal_sel0_reg;
  logic [4:0] driver_pulldown_cal_sel0_reg;
  logic [3:0] precharge_wait_cycles_reg;
  logic [3:0] autoprecharge_recovery_cycles_reg;
  logic [3:0] cmd_err_reg;
  logic [3:0] cmd_err_next;
  logic [5:0] queue_age_initial_reg;
  logic [5:0] queue_age_param_reg;
  logic       auto_precharge_enable_reg;
  logic       aging_enable_reg;
  logic       ocd_done_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [NUM_CS-1:0] term_reg;
  logic [NUM_SLOT-1:0] expired;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic hit_map    = (reg_addr == OFF_TERM_MAP);
  wire logic hit_ocd    = (reg_addr == OFF_OCD_PRE);
  wire logic hit_aging  = (reg_addr == OFF_AGING);
  wire logic hit_ctrl   = (reg_addr == OFF_CTRL);
  wire logic hit_status = (reg_addr == OFF_STATUS);
  wire logic wr_map     = ce && reg_write && hit_map;
  wire logic wr_ocd     = ce && reg_write && hit_ocd;
  wire logic wr_aging   = ce && reg_write && hit_aging;
  wire logic wr_ctrl    = ce && reg_write && hit_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Map and timing registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      read_term_map_sel0_reg <= TERM_MAP_RST;
      read_term_map_sel1_reg <= TERM_MAP_RST;
      read_term_map_sel2_reg <= TERM_MAP_RST;
      read_term_map_sel3_reg <= TERM_MAP_RST;
    end
    else if (wr_map)
    begin
      read_term_map_sel0_reg <= reg_wdata[TERM_MAP_LSB0 +: 4];
      read_term_map_sel1_reg <= reg_wdata[TERM_MAP_LSB1 +: 4];
      read_term_map_sel2_reg <= reg_wdata[TERM_MAP_LSB2 +: 4];
      read_term_map_sel3_reg <= reg_wdata[TERM_MAP_LSB3 +: 4];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      driver_pullup_cal_sel0_reg        <= CAL_RST;
      driver_pulldown_cal_sel0_reg      <= CAL_RST;
      precharge_wait_cycles_reg         <= TIMING_RST;
      autoprecharge_recovery_cycles_reg <= TIMING_RST;
    end
    else if (wr_ocd)
    begin
      driver_pullup_cal_sel0_reg        <= reg_wdata[PULLUP_LSB +: 5];
      driver_pulldown_cal_sel0_reg      <= reg_wdata[PULLDOWN_LSB +: 5];
      precharge_wait_cycles_reg         <= reg_wdata[PRE_WAIT_LSB +: 4];
      autoprecharge_recovery_cycles_reg <= reg_wdata[AP_REC_LSB +: 4];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      queue_age_initial_reg <= AGE_RST;
      queue_age_param_reg   <= AGE_RST;
    end
    else if (wr_aging)
    begin
      queue_age_initial_reg <= reg_wdata[AGE_INIT_LSB +: 6];
      queue_age_param_reg   <= reg_wdata[AGE_PARAM_LSB +: 6];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      auto_precharge_enable_reg <= 1'b0;
      aging_enable_reg          <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      auto_precharge_enable_reg <= reg_wdata[CTRL_AP_EN_BIT];
      aging_enable_reg          <= reg_wdata[CTRL_AGING_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-port error code, sticky; a new error beats a same-cycle clear
  wire logic [3:0] err_clr = wr_ctrl ? reg_wdata[CTRL_ERR_CLR_LSB +: 4]
                                     : 4'h0;
  wire logic [3:0] err_set = host_err_valid ? host_err_code : 4'h0;
  assign cmd_err_next = (cmd_err_reg & ~err_clr) | err_set;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cmd_err_reg <= CMD_ERR_RST;
    else if (ce)
      cmd_err_reg <= cmd_err_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read termination select
  function automatic logic [3:0] term_map_of(
    input logic [1:0] sel,
    input logic [3:0] m0,
    input logic [3:0] m1,
    input logic [3:0] m2,
    input logic [3:0] m3
  );
    if (sel == 2'h3)
      term_map_of = m3;
    else if (sel == 2'h2)
      term_map_of = m2;
    else if (sel == 2'h1)
      term_map_of = m1;
    else
      term_map_of = m0;
  endfunction

  // Map bit n drives termination on select n
  wire logic [3:0] term_sel = term_map_of(rd_cmd_sel,
                                          read_term_map_sel0_reg,
                                          read_term_map_sel1_reg,
                                          read_term_map_sel2_reg,
                                          read_term_map_sel3_reg);
  wire logic [3:0] term_next = rd_cmd_valid ? term_sel : 4'h0;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      term_reg <= 4'h0;
    else if (ce)
      term_reg <= term_next;
  end

  assign term_enable = term_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Driver calibration issue during init
  dcoat_ocd_state_type ocd_state_reg;
  dcoat_ocd_state_type ocd_state_next;
  logic [4:0] pullup_out_reg;
  logic [4:0] pulldown_out_reg;

  always_comb
  begin
    ocd_state_next = ocd_state_reg;
    case (ocd_state_reg)
      OCD_IDLE:
        if (ocd_init_start)
          ocd_state_next = OCD_ISSUE;
      OCD_ISSUE:
        if (ocd_cmd_ack)
          ocd_state_next = OCD_DONE;
      OCD_DONE:
        if (ocd_init_start)
          ocd_state_next = OCD_ISSUE;
      default:
        ocd_state_next = OCD_IDLE;
    endcase
  end

  wire logic ocd_load = ocd_init_start && ocd_state_reg != OCD_ISSUE;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ocd_state_reg    <= OCD_IDLE;
      pullup_out_reg   <= CAL_RST;
      pulldown_out_reg <= CAL_RST;
    end
    else if (ce)
    begin
      ocd_state_reg <= ocd_state_next;
      if (ocd_load)
      begin
        pullup_out_reg   <= driver_pullup_cal_sel0_reg;
        pulldown_out_reg <= driver_pulldown_cal_sel0_reg;
      end
    end
  end

  // Values are captured at start so a late register write cannot tear them
  assign ocd_cmd_valid = (ocd_state_reg == OCD_ISSUE);
  assign ocd_pullup    = pullup_out_reg;
  assign ocd_pulldown  = pulldown_out_reg;
  assign ocd_done_reg  = (ocd_state_reg == OCD_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank recovery timers; precharge wins a same-bank collision
  logic [3:0] bank_cnt_reg [NUM_BANK];
  wire logic ap_take = write_ap_issue && auto_precharge_enable_reg;

  genvar b;
  generate
    for (b = 0; b < NUM_BANK; b++)
    begin : g_bank
      wire logic pre_hit = precharge_issue && precharge_bank == 3'(b);
      wire logic ap_hit  = ap_take && write_ap_bank == 3'(b);
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          bank_cnt_reg[b] <= 4'h0;
        else if (ce)
        begin
          if (pre_hit)
            bank_cnt_reg[b] <= precharge_wait_cycles_reg;
          else if (ap_hit)
            bank_cnt_reg[b] <= autoprecharge_recovery_cycles_reg;
          else if (bank_cnt_reg[b] != 4'h0)
            bank_cnt_reg[b] <= bank_cnt_reg[b] - 4'h1;
        end
      end
      assign bank_ready[b] = (bank_cnt_reg[b] == 4'h0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Command aging
  dcoat_aging u_aging (
    .clock       (clock),
    .rst         (rst),
    .ce          (ce),
    .enable      (aging_enable_reg),
    .age_initial (queue_age_initial_reg),
    .age_param   (queue_age_param_reg),
    .enq_valid   (enq_valid),
    .enq_slot    (enq_slot),
    .svc_valid   (svc_valid),
    .svc_slot    (svc_slot),
    .slot_busy   (slot_busy),
    .expired     (expired),
    .prio_valid  (prio_valid),
    .prio_slot   (prio_slot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  logic [DATA_W-1:0] map_word;
  logic [DATA_W-1:0] ocd_word;
  logic [DATA_W-1:0] aging_word;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] status_word;

  always_comb
  begin
    map_word = '0;
    map_word[TERM_MAP_LSB0 +: 4] = read_term_map_sel0_reg;
    map_word[TERM_MAP_LSB1 +: 4] = read_term_map_sel1_reg;
    map_word[TERM_MAP_LSB2 +: 4] = read_term_map_sel2_reg;
    map_word[TERM_MAP_LSB3 +: 4] = read_term_map_sel3_reg;
    ocd_word = '0;
    ocd_word[PULLUP_LSB +: 5]   = driver_pullup_cal_sel0_reg;
    ocd_word[PULLDOWN_LSB +: 5] = driver_pulldown_cal_sel0_reg;
    ocd_word[PRE_WAIT_LSB +: 4] = precharge_wait_cycles_reg;
    ocd_word[AP_REC_LSB +: 4]   = autoprecharge_recovery_cycles_reg;
    ocd_word[CMD_ERR_LSB +: 4]  = cmd_err_reg;
    aging_word = '0;
    aging_word[AGE_INIT_LSB +: 6]  = queue_age_initial_reg;
    aging_word[AGE_PARAM_LSB +: 6] = queue_age_param_reg;
    ctrl_word = '0;
    ctrl_word[CTRL_AP_EN_BIT]    = auto_precharge_enable_reg;
    ctrl_word[CTRL_AGING_EN_BIT] = aging_enable_reg;
    status_word = '0;
    status_word[STAT_OCD_DONE_BIT]           = ocd_done_reg;
    status_word[STAT_BANK_RDY_LSB +: NUM_BANK] = bank_ready;
    status_word[STAT_EXPIRED_LSB +: NUM_SLOT]  = expired;
  end

  assign rdata_next = hit_map    ? map_word
                    : hit_ocd    ? ocd_word
                    : hit_aging  ? aging_word
                    : hit_ctrl   ? ctrl_word
                    : hit_status ? status_word
                    : '0;

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (ce)
      rdata_reg <= reg_read ? rdata_next : '0;
  end

  assign reg_rdata = rdata_reg;

endmodule // dcoat_ctrl

// [dcoat_checker.sv]
// Purpose: Port-level assertions for dcoat_ctrl
// Assumes: Shadows track every accepted write
// Notes:   Bank counters mirrored for exact ready timing
`timescale 1ns/10ps
module dcoat_checker
  import dcoat_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [11:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [63:0] reg_rdata,
  input wire logic        rd_cmd_valid,
  input wire logic [1:0]  rd_cmd_sel,
  input wire logic [3:0]  term_enable,
  input wire logic        ocd_init_start,
  input wire logic        ocd_cmd_ack,
  input wire logic        ocd_cmd_valid,
  input wire logic [4:0]  ocd_pullup,
  input wire logic [4:0]  ocd_pulldown,
  input wire logic        precharge_issue,
  input wire logic [2:0]  precharge_bank,
  input wire logic        write_ap_issue,
  input wire logic [2:0]  write_ap_bank,
  input wire logic [7:0]  bank_ready,
  input wire logic        host_err_valid,
  input wire logic [3:0]  host_err_code,
  input wire logic        enq_valid,
  input wire logic [1:0]  enq_slot,
  input wire logic        svc_valid,
  input wire logic [1:0]  svc_slot,
  input wire logic [3:0]  slot_busy,
  input wire logic        prio_valid
);
  logic [63:0] w80_reg, w90_reg, wa0_reg, wf0_reg;
  logic [3:0]  err_reg;
  logic [3:0]  cnt_reg [NUM_BANK];
  logic [7:0]  exp_ready;
  wire         wr_ok = ce && reg_write;
  wire [3:0]   map_pick = w80_reg[8*rd_cmd_sel +: 4];
  wire [4:0]   pu_w = w90_reg[60:56];
  wire [4:0]   pd_w = w90_reg[52:48];
  wire         ap_en = wf0_reg[CTRL_AP_EN_BIT];
  wire         age_zero = wf0_reg[1] && wa0_reg[37:32] == 6'h00;
  wire [3:0]   clr_w = (wr_ok && reg_addr == OFF_CTRL) ?
                       reg_wdata[7:4] : 4'h0;
  wire [3:0]   set_w = host_err_valid ? host_err_code : 4'h0;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      w80_reg <= '0;
      w90_reg <= '0;
      wa0_reg <= '0;
      wf0_reg <= '0;
      err_reg <= 4'h0;
    end
    else if (ce)
    begin
      // Set beats a same-cycle clear
      err_reg <= (err_reg & ~clr_w) | set_w;
      if (wr_ok && reg_addr == OFF_TERM_MAP)
        w80_reg <= reg_wdata;
      if (wr_ok && reg_addr == OFF_OCD_PRE)
        w90_reg <= reg_wdata;
      if (wr_ok && reg_addr == OFF_AGING)
        wa0_reg <= reg_wdata;
      if (wr_ok && reg_addr == OFF_CTRL)
        wf0_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_reg <= '{default: 4'h0};
    else if (ce)
      for (int b = 0; b < NUM_BANK; b++)
        if (precharge_issue && precharge_bank == 3'(b))
          cnt_reg[b] <= w90_reg[43:40];
        else if (write_ap_issue && ap_en && write_ap_bank == 3'(b))
          cnt_reg[b] <= w90_reg[35:32];
        else if (cnt_reg[b] != 4'h0)
          cnt_reg[b] <= cnt_reg[b] - 4'h1;
  end

  always_comb
    for (int b = 0; b < NUM_BANK; b++)
      exp_ready[b] = cnt_reg[b] == 4'h0;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_TERM_LOW: assert property (
    ce && rd_cmd_valid && rd_cmd_sel != 2'h3 |=>
      term_enable == $past(map_pick)) else $error("term map wrong");
  AST_TERM_HI: assert property (
    ce && rd_cmd_valid && rd_cmd_sel == 2'h3 |=>
      term_enable == $past(map_pick)) else $error("sel3 map wrong");
  AST_TERM_IDLE: assert property (
    ce && !rd_cmd_valid |=> term_enable == 4'h0)
    else $error("term without read");
  AST_OCD_PUP: assert property (
    ce && ocd_init_start && !ocd_cmd_valid |=>
      ocd_cmd_valid && ocd_pullup == $past(pu_w)) else $error("pullup");
  AST_OCD_PDN: assert property (
    ce && ocd_init_start && !ocd_cmd_valid |=>
      ocd_cmd_valid && ocd_pulldown == $past(pd_w)) else $error("pulldn");
  AST_OCD_HOLD: assert property (
    ce && ocd_cmd_valid && !ocd_cmd_ack |=> ocd_cmd_valid &&
      $stable(ocd_pullup) && $stable(ocd_pulldown)) else $error("ocd drop");
  AST_PRE_WAIT: assert property (
    ce && precharge_issue |=> bank_ready == exp_ready)
    else $error("precharge wait");
  AST_AP_REC: assert property (
    ce && write_ap_issue && ap_en |=> bank_ready == exp_ready)
    else $error("ap recovery");
  AST_AP_OFF: assert property (
    ce && write_ap_issue && !ap_en |=> bank_ready == exp_ready)
    else $error("ap not ignored");
  AST_ERR_RO: assert property (
    ce && reg_read && reg_addr == OFF_OCD_PRE |=>
      reg_rdata[19:16] == $past(err_reg)) else $error("error code");
  AST_AGE_LOAD: assert property (
    ce && enq_valid |=> slot_busy[$past(enq_slot)])
    else $error("enqueue lost");
  AST_AGE_ZERO: assert property (
    ce && enq_valid && age_zero |=> prio_valid)
    else $error("zero age not expired");
  AST_SVC_FREE: assert property (
    ce && svc_valid && !(enq_valid && enq_slot == svc_slot) |=>
      !slot_busy[$past(svc_slot)]) else $error("service not freed");
endmodule // dcoat_checker

bind dcoat_ctrl dcoat_checker u_chk (.*);

// [dcoat_mem_model.sv]
// Purpose: Memory side acking calibration commands
// Assumes: Ack delay steady during a command
// Notes:   Ack is a one-cycle pulse, low while idle
`timescale 1ns/10ps
module dcoat_mem_model
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] ack_delay,
  input  wire logic       ocd_cmd_valid,
  input  wire logic [4:0] ocd_pullup,
  input  wire logic [4:0] ocd_pulldown,
  output logic            ocd_cmd_ack,
  output logic [4:0]      got_pu,
  output logic [4:0]      got_pd,
  output logic [7:0]      ack_count
);
  logic [3:0] wait_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ocd_cmd_ack <= 1'b0;
      got_pu <= 5'h00;
      got_pd <= 5'h00;
      ack_count <= 8'h00;
      wait_reg <= 4'h0;
    end
    else if (ocd_cmd_valid && !ocd_cmd_ack)
    begin
      if (wait_reg == ack_delay)
      begin
        ocd_cmd_ack <= 1'b1;
        got_pu <= ocd_pullup;
        got_pd <= ocd_pulldown;
        ack_count <= ack_count + 8'h01;
        wait_reg <= 4'h0;
      end
      else
        wait_reg <= wait_reg + 4'h1;
    end
    else
      ocd_cmd_ack <= 1'b0;
  end
endmodule // dcoat_mem_model

// [testbench.sv]
// Purpose: Directed tests for dcoat_ctrl
// Assumes: Clock enable held high throughout
// Notes:   Expected values come from the field layout only
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench
  import dcoat_pkg::*;
;
  logic clock, rst, ce, reg_write, reg_read, rd_cmd_valid, ocd_init_start;
  logic ocd_cmd_ack, ocd_cmd_valid, precharge_issue, write_ap_issue;
  logic host_err_valid, enq_valid, svc_valid, prio_valid;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [1:0]        rd_cmd_sel, enq_slot, svc_slot, prio_slot;
  logic [2:0]        precharge_bank, write_ap_bank;
  logic [3:0]        term_enable, host_err_code, ack_delay, slot_busy;
  logic [4:0]        ocd_pullup, ocd_pulldown, got_pu, got_pd;
  logic [7:0]        bank_ready, ack_count;
  logic [11:0]       addrs [4] = '{OFF_TERM_MAP, OFF_OCD_PRE, OFF_AGING,
                                   12'h0c8};
  logic [63:0]       masks [4] = '{64'h0f0f_0f0f, 64'h1f1f_0f0f_0000_0000,
                                   64'h3f_3f00_0000, 64'h0};
  logic [63:0]       pvals [2] = '{64'h0a15_0000_0000_0000,
                                   64'h150a_0305_0000_0000};
  logic [3:0]        maps [4] = '{4'h3, 4'h5, 4'h9, 4'hc};
  int                checks = 0, miscompares = 0, cyc = 0, low;

  dcoat_ctrl dut (.*);
  dcoat_mem_model mem (.*);

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic pulse(input logic [3:0] p);
    @(posedge clock);
    {ocd_init_start, precharge_issue, write_ap_issue, enq_valid} <= p;
    @(posedge clock);
    {ocd_init_start, precharge_issue, write_ap_issue, enq_valid} <= 4'h0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Ceiling well above the directed run
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    {rst, ce} = 2'b11;
    {reg_write, reg_read, rd_cmd_valid, ocd_init_start, precharge_issue,
     write_ap_issue, host_err_valid, enq_valid, svc_valid, reg_addr,
     reg_wdata, rd_cmd_sel, enq_slot, svc_slot, precharge_bank,
     write_ap_bank, host_err_code, ack_delay} = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(addrs[i], 64'h0);
    rd(OFF_STATUS, 64'hff00);
    for (int i = 0; i < 4; i++)
    begin
      wr(addrs[i], '1);
      rd(addrs[i], masks[i]);
    end
    wr(OFF_TERM_MAP, 64'h0c09_0503);
    for (int s = 0; s < 5; s++)
    begin
      @(posedge clock);
      rd_cmd_valid <= (s < 4);
      rd_cmd_sel <= 2'(s);
      #1;
      if (s > 0)
        `CHK("term_enable", maps[s-1], term_enable)
    end
    tick();
    `CHK("term_idle", 4'h0, term_enable)
    for (int k = 0; k < 2; k++)
    begin
      ack_delay <= 4'(3 * k);
      wr(OFF_OCD_PRE, pvals[k]);
      pulse(4'h8);
      for (int i = 0; i < 30 && ack_count != 8'(k + 1); i++)
        tick();
      `CHK("pullup", pvals[k][60:56], got_pu)
      `CHK("pulldown", pvals[k][52:48], got_pd)
    end
    rd(OFF_STATUS, 64'hff01);
    precharge_bank <= 3'h2;
    pulse(4'h4);
    #1;
    for (int i = 0; i < 4; i++)
    begin
      `CHK("bank_ready", (i < 3) ? 8'hfb : 8'hff, bank_ready)
      tick();
    end
    for (int en = 0; en < 2; en++)
    begin
      wr(OFF_CTRL, 64'(en));
      write_ap_bank <= 3'h5;
      pulse(4'h2);
      low = 0;
      repeat (8)
      begin
        #1;
        low += (bank_ready[5] === 1'b0);
        @(posedge clock);
      end
      `CHK("ap_block", en * 5, low)
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      host_err_valid <= 1'b1;
      host_err_code <= 4'(1 << i);
    end
    @(posedge clock);
    host_err_valid <= 1'b0;
    wr(OFF_OCD_PRE, 64'h0);
    rd(OFF_OCD_PRE, 64'hf_0000);
    wr(OFF_CTRL, 64'h51);
    rd(OFF_OCD_PRE, 64'ha_0000);
    wr(OFF_AGING, 64'h1_0000_0000);
    wr(OFF_CTRL, 64'h3);
    enq_slot <= 2'h1;
    pulse(4'h1);
    svc_valid <= 1'b1;
    #1;
    `CHK("busy_prio", 5'h04, {slot_busy, prio_valid})
    @(posedge clock);
    svc_valid <= 1'b0;
    #1;
    `CHK("expired", 3'h5, {prio_valid, prio_slot})
    @(posedge clock);
    svc_valid <= 1'b1;
    svc_slot <= 2'h1;
    @(posedge clock);
    svc_valid <= 1'b0;
    #1;
    `CHK("freed", 5'h00, {slot_busy, prio_valid})
    wr(OFF_AGING, 64'h0);
    enq_slot <= 2'h3;
    pulse(4'h1);
    #1;
    `CHK("zero_age", 3'h7, {prio_valid, prio_slot})
    summarize();
  end
endmodule // testbench
